/* File: src/ltssm_ctrl_pkg.sv */
// Constants, register map and types for the link training control block.
// Assumes a 100 MHz aclk and an AXI4-Lite master with 32-bit data.
package ltssm_ctrl_pkg;

  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_REQ = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status word layout
  localparam int ST_STATE_LSB = 0;
  localparam int ST_IDLE_BIT = 4;
  localparam int ST_BEACON_BIT = 5;
  localparam int ST_FTS_BIT = 6;
  localparam int ST_SCR_EN_BIT = 7;
  localparam int ST_DETECT_LSB = 8;
  localparam int ST_LINKED_LSB = 16;

  localparam int CTRL_W = 9;
  localparam int REQ_W = 11;

  localparam int CLK_PERIOD_NS = 10;
  localparam int HOT_RESET_NS = 1000;
  // Least time, so round up
  localparam int HOT_RESET_CYCLES = (HOT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Order gives the reported state code, Detect first
  typedef enum logic [3:0] {
    ST_DETECT, ST_POLLING, ST_CONFIG, ST_L0, ST_L0S, ST_L1, ST_L2,
    ST_RECOVERY, ST_LOOPBACK, ST_HOT_RESET, ST_DISABLED
  } ltssm_state_t;

  // Level controls, bit 0 is bypass
  typedef struct packed {
    logic standby_fts;
    logic tx_standby;
    logic beacon;
    logic scramble_off;
    logic force_scr_off;
    logic force_detect;
    logic force_idle;
    logic force_linked;
    logic bypass;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '0;

  // One-shot transition requests, bit 0 is go-to-disabled
  typedef struct packed {
    logic [3:0] loopback;
    logic goto_config;
    logic goto_recovery;
    logic goto_l2;
    logic goto_l1;
    logic goto_hot_reset;
    logic goto_detect;
    logic goto_disabled;
  } req_t;

  localparam req_t REQ_RESET = '0;

endpackage

/* File: src/link_training_state_control.sv */
// Link training state machine with its control and status port.
// Assumes an AXI4-Lite master on aclk; force pins and PHY status are asynchronous.
// Summary of operation
// - Bypass input forces training straight to L0
// - Force-linked puts every lane in linked state
// - Force idle acts as detected electrical idle
// - Force detect reports receivers while in Detect
// - Force scrambler off disables packet scrambling
// - Beacon request level makes device send beacon
// - Scramble-off request sets TS1/TS2 disable bit
// - Disabled request honoured in Configuration or Recovery
// - Detect request honoured in L2 or Disabled
// - Hot reset request honoured in Recovery only
// - Standby request enters L0s only from L0
// - Fast training request in L0s sends FTS
// - L1 request honoured only from L0
// - L2 request honoured only from L0
// - Loopback request honoured in Configuration or Recovery
// - Recovery request honoured from L0, L0s, L1
// - Configuration request honoured only from Recovery
// - Current state reported as 4-bit code
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

module link_training_state_control #(
  parameter int LANES = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic train_bypass,
  input wire logic force_linked,
  input wire logic force_rx_idle_detect,
  input wire logic force_rx_detect,
  input wire logic force_scrambler_off,
  input wire logic scramble_off_request,
  input wire logic goto_disabled_request,
  input wire logic [LANES-1:0] phy_rx_present,
  input wire logic phy_rx_elec_idle,
  input wire logic train_step,
  output logic [3:0] ltssm_state,
  output logic [LANES-1:0] lane_linked,
  output logic [LANES-1:0] rx_detected,
  output logic rx_idle_detected,
  output logic scrambler_enable,
  output logic tx_beacon,
  output logic ts_scramble_disable,
  output logic tx_fts
);

  localparam int NASYNC = 8 + LANES;

  ltssm_ctrl_pkg::ctrl_t ctrl_q;
  ltssm_ctrl_pkg::req_t req_q;
  ltssm_ctrl_pkg::ltssm_state_t st_q, st_d;
  logic [NASYNC-1:0] async_in, meta_q, sync_q;
  logic bypass_s, linked_s, idle_s, detect_s, scr_off_s, ts_off_s, dis_pin_s, elec_idle_s;
  logic [LANES-1:0] present_s, present_eff;
  logic bypass_eff, linked_eff, idle_eff, scr_off_eff, ts_off_eff, dis_req;
  logic [15:0] hr_cnt_q;
  logic hr_done;
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, ctrl_merged, req_merged;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_write;
  logic [31:0] status_word;
  logic [3:0] state_q;
  logic [LANES-1:0] linked_q, detected_q;
  logic idle_q, scr_en_q, beacon_q, ts_bit_q, fts_q;

  // Async pins into the clock domain, two flops each
  assign async_in = {phy_rx_present, phy_rx_elec_idle, goto_disabled_request,
                     scramble_off_request, force_scrambler_off, force_rx_detect,
                     force_rx_idle_detect, force_linked, train_bypass};

  genvar gi;
  generate
    for (gi = 0; gi < NASYNC; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign bypass_s = sync_q[0];
  assign linked_s = sync_q[1];
  assign idle_s = sync_q[2];
  assign detect_s = sync_q[3];
  assign scr_off_s = sync_q[4];
  assign ts_off_s = sync_q[5];
  assign dis_pin_s = sync_q[6];
  assign elec_idle_s = sync_q[7];
  assign present_s = sync_q[NASYNC-1:8];

  // Pin and register controls are equivalent
  assign bypass_eff = bypass_s | ctrl_q.bypass;
  assign linked_eff = linked_s | ctrl_q.force_linked;
  assign idle_eff = idle_s | ctrl_q.force_idle | elec_idle_s;
  assign scr_off_eff = scr_off_s | ctrl_q.force_scr_off;
  assign ts_off_eff = ts_off_s | ctrl_q.scramble_off;
  assign dis_req = dis_pin_s | req_q.goto_disabled;
  // Forced presence only counts in Detect
  assign present_eff = present_s |
      {LANES{(detect_s | ctrl_q.force_detect) && st_q == ltssm_ctrl_pkg::ST_DETECT}};

  assign hr_done = hr_cnt_q == 16'(ltssm_ctrl_pkg::HOT_RESET_CYCLES - 1);

  // Requests are acted on only in their own states, otherwise dropped
  always_comb begin
    st_d = st_q;
    if (bypass_eff) begin
      st_d = ltssm_ctrl_pkg::ST_L0;
    end else begin
      unique case (st_q)
        ltssm_ctrl_pkg::ST_DETECT: begin
          if (|present_eff) st_d = ltssm_ctrl_pkg::ST_POLLING;
        end
        ltssm_ctrl_pkg::ST_POLLING: begin
          if (train_step) st_d = ltssm_ctrl_pkg::ST_CONFIG;
        end
        ltssm_ctrl_pkg::ST_CONFIG: begin
          if (dis_req) st_d = ltssm_ctrl_pkg::ST_DISABLED;
          else if (|req_q.loopback) st_d = ltssm_ctrl_pkg::ST_LOOPBACK;
          else if (train_step) st_d = ltssm_ctrl_pkg::ST_L0;
        end
        ltssm_ctrl_pkg::ST_L0: begin
          if (req_q.goto_recovery || idle_eff) st_d = ltssm_ctrl_pkg::ST_RECOVERY;
          else if (req_q.goto_l1) st_d = ltssm_ctrl_pkg::ST_L1;
          else if (req_q.goto_l2) st_d = ltssm_ctrl_pkg::ST_L2;
          else if (ctrl_q.tx_standby) st_d = ltssm_ctrl_pkg::ST_L0S;
        end
        ltssm_ctrl_pkg::ST_L0S: begin
          if (req_q.goto_recovery) st_d = ltssm_ctrl_pkg::ST_RECOVERY;
          else if (!ctrl_q.tx_standby && !ctrl_q.standby_fts) st_d = ltssm_ctrl_pkg::ST_L0;
        end
        ltssm_ctrl_pkg::ST_L1: begin
          if (req_q.goto_recovery || !idle_eff) st_d = ltssm_ctrl_pkg::ST_RECOVERY;
        end
        ltssm_ctrl_pkg::ST_L2: begin
          if (req_q.goto_detect) st_d = ltssm_ctrl_pkg::ST_DETECT;
        end
        ltssm_ctrl_pkg::ST_RECOVERY: begin
          if (dis_req) st_d = ltssm_ctrl_pkg::ST_DISABLED;
          else if (req_q.goto_hot_reset) st_d = ltssm_ctrl_pkg::ST_HOT_RESET;
          else if (req_q.goto_config) st_d = ltssm_ctrl_pkg::ST_CONFIG;
          else if (|req_q.loopback) st_d = ltssm_ctrl_pkg::ST_LOOPBACK;
          else if (train_step) st_d = ltssm_ctrl_pkg::ST_L0;
        end
        ltssm_ctrl_pkg::ST_LOOPBACK: begin
          if (train_step) st_d = ltssm_ctrl_pkg::ST_DETECT;
        end
        ltssm_ctrl_pkg::ST_HOT_RESET: begin
          if (hr_done) st_d = ltssm_ctrl_pkg::ST_DETECT;
        end
        ltssm_ctrl_pkg::ST_DISABLED: begin
          if (req_q.goto_detect) st_d = ltssm_ctrl_pkg::ST_DETECT;
        end
        default: st_d = ltssm_ctrl_pkg::ST_DETECT;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) st_q <= ltssm_ctrl_pkg::ST_DETECT;
    else st_q <= st_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || st_q != ltssm_ctrl_pkg::ST_HOT_RESET) hr_cnt_q <= '0;
    else if (!hr_done) hr_cnt_q <= hr_cnt_q + 16'h0001;
  end

  // Registered PHY-facing outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= 4'h0;
      linked_q <= '0;
      detected_q <= '0;
      idle_q <= 1'b0;
      scr_en_q <= 1'b1;
      beacon_q <= 1'b0;
      ts_bit_q <= 1'b0;
      fts_q <= 1'b0;
    end else begin
      state_q <= st_d;
      linked_q <= {LANES{linked_eff || st_d == ltssm_ctrl_pkg::ST_L0}};
      detected_q <= present_eff;
      idle_q <= idle_eff;
      scr_en_q <= !scr_off_eff;
      beacon_q <= ctrl_q.beacon;
      ts_bit_q <= ts_off_eff;
      fts_q <= ctrl_q.standby_fts && st_d == ltssm_ctrl_pkg::ST_L0S;
    end
  end

  assign ltssm_state = state_q;
  assign lane_linked = linked_q;
  assign rx_detected = detected_q;
  assign rx_idle_detected = idle_q;
  assign scrambler_enable = scr_en_q;
  assign tx_beacon = beacon_q;
  assign ts_scramble_disable = ts_bit_q;
  assign tx_fts = fts_q;

  // AXI4-Lite write: address and data taken in either order
  assign awready = !aw_held_q && !bvalid_q;
  assign wready = !w_held_q && !bvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[8*b +: 8] = nw[8*b +: 8];
    end
    return res;
  endfunction

  assign ctrl_merged = merge(32'(ctrl_q), wdata_q, wstrb_q);
  assign req_merged = merge(32'h0, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ltssm_ctrl_pkg::CTRL_RESET;
    end else if (do_write && awaddr_q[11:2] == ltssm_ctrl_pkg::OFF_CTRL[11:2]) begin
      ctrl_q <= ltssm_ctrl_pkg::ctrl_t'(ctrl_merged[ltssm_ctrl_pkg::CTRL_W-1:0]);
    end
  end

  // Requests live one cycle, so a mismatched one is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= ltssm_ctrl_pkg::REQ_RESET;
    end else if (do_write && awaddr_q[11:2] == ltssm_ctrl_pkg::OFF_REQ[11:2]) begin
      req_q <= ltssm_ctrl_pkg::req_t'(req_merged[ltssm_ctrl_pkg::REQ_W-1:0]);
    end else begin
      req_q <= ltssm_ctrl_pkg::REQ_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= ltssm_ctrl_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (awaddr_q[11:2] == ltssm_ctrl_pkg::OFF_CTRL[11:2] ||
                  awaddr_q[11:2] == ltssm_ctrl_pkg::OFF_REQ[11:2]) ?
                 ltssm_ctrl_pkg::RESP_OKAY : ltssm_ctrl_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_comb begin
    status_word = '0;
    status_word[ltssm_ctrl_pkg::ST_STATE_LSB +: 4] = st_q;
    status_word[ltssm_ctrl_pkg::ST_IDLE_BIT] = idle_q;
    status_word[ltssm_ctrl_pkg::ST_BEACON_BIT] = beacon_q;
    status_word[ltssm_ctrl_pkg::ST_FTS_BIT] = fts_q;
    status_word[ltssm_ctrl_pkg::ST_SCR_EN_BIT] = scr_en_q;
    status_word[ltssm_ctrl_pkg::ST_DETECT_LSB +: LANES] = detected_q;
    status_word[ltssm_ctrl_pkg::ST_LINKED_LSB +: LANES] = linked_q;
  end

  // Read: one answer outstanding, request register reads as zero
  assign arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= ltssm_ctrl_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= ltssm_ctrl_pkg::RESP_OKAY;
      if (araddr[11:2] == ltssm_ctrl_pkg::OFF_CTRL[11:2]) rdata_q <= 32'(ctrl_q);
      else if (araddr[11:2] == ltssm_ctrl_pkg::OFF_REQ[11:2]) rdata_q <= '0;
      else if (araddr[11:2] == ltssm_ctrl_pkg::OFF_STATUS[11:2]) rdata_q <= status_word;
      else begin
        rdata_q <= '0;
        rresp_q <= ltssm_ctrl_pkg::RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_in_cfg_or_rec;
    !bypass_eff && (st_q == ltssm_ctrl_pkg::ST_CONFIG || st_q == ltssm_ctrl_pkg::ST_RECOVERY);
  endsequence

  sequence s_pin_held;
    force_scrambler_off [*3];
  endsequence

  a_bypass_to_l0: assert property (bypass_eff |=> st_q == ltssm_ctrl_pkg::ST_L0 &&
    ltssm_state == 4'h3) else $error("bypass did not reach L0");
  a_force_linked: assert property (linked_eff |=> &lane_linked)
    else $error("lanes not linked under force");
  a_force_idle: assert property (ctrl_q.force_idle |=> rx_idle_detected)
    else $error("idle not reported under force");
  a_force_detect: assert property (ctrl_q.force_detect && st_q == ltssm_ctrl_pkg::ST_DETECT
    |=> &rx_detected) else $error("receivers not reported in Detect");
  a_scr_forced_off: assert property (ctrl_q.force_scr_off |=> !scrambler_enable)
    else $error("scrambler still enabled");
  a_beacon_level: assert property (ctrl_q.beacon |=> tx_beacon)
    else $error("beacon not sent");
  a_ts_bit_set: assert property (ctrl_q.scramble_off |=> ts_scramble_disable)
    else $error("training set bit not set");
  a_goto_disabled: assert property (s_in_cfg_or_rec ##0 dis_req
    |=> st_q == ltssm_ctrl_pkg::ST_DISABLED) else $error("disabled request not taken");
  a_goto_detect: assert property (!bypass_eff && req_q.goto_detect &&
    (st_q == ltssm_ctrl_pkg::ST_L2 || st_q == ltssm_ctrl_pkg::ST_DISABLED)
    |=> st_q == ltssm_ctrl_pkg::ST_DETECT) else $error("detect request not taken");
  a_goto_hot_reset: assert property (!bypass_eff && !dis_req && req_q.goto_hot_reset &&
    st_q == ltssm_ctrl_pkg::ST_RECOVERY |=> st_q == ltssm_ctrl_pkg::ST_HOT_RESET ##99
    st_q == ltssm_ctrl_pkg::ST_HOT_RESET ##1 st_q == ltssm_ctrl_pkg::ST_DETECT)
    else $error("hot reset entry or length wrong");
  a_standby_l0s: assert property (!bypass_eff && ctrl_q.tx_standby && !idle_eff &&
    st_q == ltssm_ctrl_pkg::ST_L0 && req_q == ltssm_ctrl_pkg::REQ_RESET
    |=> st_q == ltssm_ctrl_pkg::ST_L0S) else $error("standby not entered");
  a_fts_in_l0s: assert property (!bypass_eff && ctrl_q.standby_fts &&
    st_q == ltssm_ctrl_pkg::ST_L0S && !req_q.goto_recovery
    |=> st_q == ltssm_ctrl_pkg::ST_L0S && tx_fts) else $error("fast training not sent");
  a_l1_only_l0: assert property ($changed(st_q) && st_q == ltssm_ctrl_pkg::ST_L1
    |-> $past(st_q) == ltssm_ctrl_pkg::ST_L0 && $past(req_q.goto_l1))
    else $error("L1 entered without cause");
  a_l2_only_l0: assert property ($changed(st_q) && st_q == ltssm_ctrl_pkg::ST_L2
    |-> $past(st_q) == ltssm_ctrl_pkg::ST_L0 && $past(req_q.goto_l2))
    else $error("L2 entered without cause");
  a_loopback_entry: assert property (s_in_cfg_or_rec ##0 (|req_q.loopback) && !dis_req &&
    !req_q.goto_hot_reset && !req_q.goto_config |=> st_q == ltssm_ctrl_pkg::ST_LOOPBACK)
    else $error("loopback request not taken");
  a_goto_recovery: assert property (!bypass_eff && req_q.goto_recovery &&
    (st_q == ltssm_ctrl_pkg::ST_L0 || st_q == ltssm_ctrl_pkg::ST_L0S ||
     st_q == ltssm_ctrl_pkg::ST_L1) |=> st_q == ltssm_ctrl_pkg::ST_RECOVERY)
    else $error("recovery request not taken");
  a_goto_config: assert property (!bypass_eff && !dis_req && !req_q.goto_hot_reset &&
    req_q.goto_config && st_q == ltssm_ctrl_pkg::ST_RECOVERY
    |=> st_q == ltssm_ctrl_pkg::ST_CONFIG) else $error("config request not taken");
  a_req_dropped: assert property (req_q != ltssm_ctrl_pkg::REQ_RESET && !do_write
    |=> req_q == ltssm_ctrl_pkg::REQ_RESET) else $error("request held past one cycle");
  a_pin_sync_delay: assert property (s_pin_held |=> !scrambler_enable)
    else $error("pin not honoured after sync");
  a_pin_not_early: assert property (!ctrl_q.force_scr_off && $rose(force_scrambler_off)
    && !$past(meta_q[4]) && !meta_q[4] && !sync_q[4] |=> scrambler_enable)
    else $error("pin bypassed synchroniser");

endmodule

`default_nettype wire

/* File: test/phy_partner.sv */
// Stand-in for the lane side: receiver presence and training step pulses.
// Assumes bench commands change just after aclk rises.
`timescale 1ns/1ns
`default_nettype none
module phy_partner #(
  parameter int LANES = 4
) (
  input wire logic aclk,
  input wire logic present_cmd,
  input wire logic step_cmd,
  input wire logic idle_cmd,
  output logic [LANES-1:0] phy_rx_present,
  output logic phy_rx_elec_idle,
  output logic train_step
);
  logic step_q;
  always_ff @(posedge aclk) begin
    step_q <= step_cmd;
    // One pulse per command, like a real step-done flag
    train_step <= step_cmd && !step_q;
    phy_rx_present <= present_cmd ? '1 : '0;
    // Line goes quiet on command, as the far end does in L1
    phy_rx_elec_idle <= idle_cmd;
  end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the link training control block.
// Assumes the package, the design and the lane partner compile first.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, present_cmd, step_cmd, idle_cmd;
  logic [11:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, ltssm_state, lane_linked, rx_detected, phy_rx_present;
  logic [1:0] bresp, rresp, resp;
  logic train_bypass, force_linked, force_rx_idle_detect, force_rx_detect;
  logic force_scrambler_off, scramble_off_request, goto_disabled_request;
  logic phy_rx_elec_idle, train_step, rx_idle_detected, scrambler_enable;
  logic tx_beacon, ts_scramble_disable, tx_fts;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;

  link_training_state_control #(.LANES(4)) link_training_state_control_i (.aclk, .aresetn,
    .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .train_bypass, .force_linked, .force_rx_idle_detect, .force_rx_detect,
    .force_scrambler_off, .scramble_off_request, .goto_disabled_request, .phy_rx_present,
    .phy_rx_elec_idle, .train_step, .ltssm_state, .lane_linked, .rx_detected,
    .rx_idle_detected, .scrambler_enable, .tx_beacon, .ts_scramble_disable, .tx_fts);
  phy_partner #(.LANES(4)) phy_partner_i (.aclk, .present_cmd, .step_cmd, .idle_cmd,
    .phy_rx_present,
    .phy_rx_elec_idle, .train_step);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard: the whole run needs a few hundred cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      $display("ERROR at %0t: timeout", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Waits for the answer however long it takes; the hang guard ends a stuck run
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic req(input int b);
    wr(12'h004, 32'h1 << b);
  endtask

  // Bounded wait for a state code, then compare
  task automatic go(input logic [3:0] s, input int lim);
    int n;
    n = 0;
    while (ltssm_state !== s && n < lim) begin
      @(posedge aclk);
      n++;
    end
    chk(ltssm_state, s);
  endtask

  task automatic pulse();
    step_cmd <= 1'b1;
    @(posedge aclk);
    step_cmd <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    present_cmd <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  task automatic train_up();
    present_cmd <= 1'b1;
    go(4'h1, 20);
    pulse();
    go(4'h2, 10);
    pulse();
    go(4'h3, 10);
  endtask

  // Drop presence first so Detect is not left before it is seen
  task automatic to_detect();
    present_cmd <= 1'b0;
    repeat (4) @(posedge aclk);
    req(1);
    go(4'h0, 3);
  endtask

  task automatic t_pins();
    {force_linked, force_rx_idle_detect, force_scrambler_off, scramble_off_request} <= 4'hf;
    repeat (4) @(posedge aclk);
    chk(lane_linked, 4'hf);
    chk(rx_idle_detected, 1'b1);
    chk(scrambler_enable, 1'b0);
    chk(ts_scramble_disable, 1'b1);
    {force_linked, force_rx_idle_detect, force_scrambler_off, scramble_off_request} <= 4'h0;
    repeat (4) @(posedge aclk);
    chk(lane_linked, 4'h0);
    chk(scrambler_enable, 1'b1);
    force_rx_detect <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(rx_detected, 4'hf);
    force_rx_detect <= 1'b0;
    do_reset();
  endtask

  task automatic t_regs();
    rd_reg(12'h000);
    chk(rd, 32'h0);
    wr(12'h000, 32'h60);
    repeat (2) @(posedge aclk);
    chk(tx_beacon, 1'b1);
    chk(ts_scramble_disable, 1'b1);
    rd_reg(12'h008);
    chk(rd[7:0], 8'ha0);
    wr(12'h000, 32'h0);
    // Register forces; forced presence also leaves Detect for Polling
    wr(12'h000, 32'h1e);
    chk(lane_linked, 4'hf);
    chk(rx_idle_detected, 1'b1);
    chk(scrambler_enable, 1'b0);
    chk(ltssm_state, 4'h1);
    wr(12'h000, 32'h0);
    rd_reg(12'h004);
    chk(rd, 32'h0);
    wr(12'h00c, 32'h1);
    chk(resp, 2'h2);
    wr(12'h008, 32'h0);
    chk(resp, 2'h2);
    rd_reg(12'h00c);
    chk(resp, 2'h2);
  endtask

  task automatic t_moves();
    train_up();
    req(6);
    req(2);
    req(1);
    chk(ltssm_state, 4'h3);
    // Idle lands on the same edge as L1 entry, so L0 is not left for Recovery
    idle_cmd <= 1'b1;
    req(3);
    go(4'h5, 3);
    req(4);
    chk(ltssm_state, 4'h5);
    req(5);
    go(4'h7, 3);
    idle_cmd <= 1'b0;
    req(3);
    chk(ltssm_state, 4'h7);
    req(6);
    go(4'h2, 3);
    req(0);
    go(4'ha, 3);
    req(5);
    chk(ltssm_state, 4'ha);
    to_detect();
    train_up();
    req(4);
    go(4'h6, 3);
    to_detect();
  endtask

  task automatic t_loop();
    for (int i = 0; i < 4; i++) begin
      train_up();
      req(5);
      go(4'h7, 3);
      if (i[0]) begin
        req(6);
        go(4'h2, 3);
      end
      req(7 + i);
      go(4'h8, 3);
      present_cmd <= 1'b0;
      pulse();
      go(4'h0, 3);
    end
  endtask

  task automatic t_hot();
    train_up();
    req(5);
    go(4'h7, 3);
    req(2);
    go(4'h9, 3);
    present_cmd <= 1'b0;
    repeat (90) @(posedge aclk);
    chk(ltssm_state, 4'h9);
    go(4'h0, 20);
  endtask

  task automatic t_standby();
    train_up();
    wr(12'h000, 32'h80);
    go(4'h4, 3);
    chk(tx_fts, 1'b0);
    wr(12'h000, 32'h180);
    repeat (2) @(posedge aclk);
    chk(tx_fts, 1'b1);
    chk(ltssm_state, 4'h4);
    wr(12'h000, 32'h0);
    go(4'h3, 3);
    wr(12'h000, 32'h80);
    go(4'h4, 3);
    req(5);
    go(4'h7, 3);
    wr(12'h000, 32'h0);
    goto_disabled_request <= 1'b1;
    go(4'ha, 6);
    goto_disabled_request <= 1'b0;
    to_detect();
  endtask

  task automatic t_bypass();
    do_reset();
    wr(12'h000, 32'h1);
    go(4'h3, 3);
    wr(12'h000, 32'h0);
    train_bypass <= 1'b1;
    go(4'h3, 6);
    train_bypass <= 1'b0;
    do_reset();
  endtask

  initial begin
    {awaddr, araddr, awprot, arprot, wdata} = '0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready, step_cmd, idle_cmd} = '0;
    {train_bypass, force_linked, force_rx_idle_detect, force_rx_detect} = '0;
    {force_scrambler_off, scramble_off_request, goto_disabled_request} = '0;
    do_reset();
    chk(ltssm_state, 4'h0);
    chk(scrambler_enable, 1'b1);
    t_pins();
    t_regs();
    t_moves();
    t_loop();
    t_hot();
    t_standby();
    t_bypass();
    give_verdict();
  end
endmodule
`default_nettype wire
